// *** hw/cfd_pkg.sv ***
// Constants and types for the clock fan-out configuration block
package cfd_pkg;
  localparam logic [6:0] TARGET_ADDR  = 7'h38;
  localparam logic [7:0] REG_GLOBAL   = 8'h00;
  localparam logic [7:0] REG_CHAN_ONE = 8'h01;
  localparam logic [7:0] GLOBAL_RESET = 8'h44;
  localparam logic [7:0] CHAN_RESET   = 8'h06;
  localparam logic [7:0] GLOBAL_MASK  = 8'h7f;
  localparam logic [7:0] CHAN_MASK    = 8'h3f;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [3:0] LAST_BIT     = 4'h7;
  // Global register fields
  localparam int G_OUT_MODE   = 0;
  localparam int G_REQ_OPEN   = 1;
  localparam int G_REQ_POL    = 2;
  localparam int G_REQ_FORCE  = 3;
  localparam int G_DC_COUPLED = 4;
  localparam int G_LDO_LO     = 5;
  localparam int G_LDO_HI     = 6;
  localparam logic [1:0] LDO_TRACK = 2'h2;
  localparam logic [1:0] LDO_FORCE = 2'h3;
  // Channel register fields
  localparam int C_LOAD_LO   = 0;
  localparam int C_LOAD_HI   = 1;
  localparam int C_REQ_POL   = 2;
  localparam int C_FORCE_ON  = 3;
  localparam int C_FORCE_OFF = 4;
  localparam int C_PULLDOWN  = 5;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_ADDR, S_INDEX, S_ACK_INDEX,
    S_WDATA, S_ACK_DATA, S_RDATA, S_RACK
  } cfd_state_type;
endpackage

// *** hw/cfd_output_gate.sv ***
// Glitch-free enable gate for one fan-out clock output
module cfd_output_gate (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic clkEn,
  // Source clock and request
  input  wire logic sourceClk,
  input  wire logic enableReq,
  // Gated output
  output logic      gatedClk,
  output logic      enabled
);
  logic srcPrev;
  logic next_srcPrev;
  logic next_enabled;
  logic next_gatedClk;

  always_comb begin
    next_srcPrev  = sourceClk;
    next_enabled  = enabled;
    // Enable only moves while source is low, so no runt pulse
    if (srcPrev && !sourceClk) begin
      next_enabled = enableReq;
    end
    next_gatedClk = sourceClk & enabled;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srcPrev  <= 1'b0;
      enabled  <= 1'b0;
      gatedClk <= 1'b0;
    end else if (clkEn) begin
      srcPrev  <= next_srcPrev;
      enabled  <= next_enabled;
      gatedClk <= next_gatedClk;
    end
  end
endmodule

// *** hw/cfd_config_regs.sv ***
// Two-wire target, configuration registers and channel one control
module cfd_config_regs (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       clkEn,
  // Two-wire bus, data pin open drain
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  // Clock path
  input  wire logic       sourceClk,
  input  wire logic       requestInputOne,
  input  wire logic [2:0] otherRequests,
  output logic            fanoutOutputOne,
  output logic            fanoutEnabledOne,
  // Static configuration and regulator enable
  output logic            pairedOutputs,
  output logic            inputDcCoupled,
  output logic [1:0]      loadStrengthOne,
  output logic            pulldownOne,
  output logic            regulatorOn,
  // System request pin
  output logic            sysRequestOut,
  output logic            sysRequestOeN
);
  cfd_pkg::cfd_state_type state;
  cfd_pkg::cfd_state_type next_state;
  logic [3:0] bitCount;
  logic [3:0] next_bitCount;
  logic [7:0] shiftReg;
  logic [7:0] next_shiftReg;
  logic [7:0] regIndex;
  logic [7:0] next_regIndex;
  logic       readMode;
  logic       next_readMode;
  logic       sdaDrive;
  logic       next_sdaDrive;
  logic       sclPrev;
  logic       sdaPrev;
  logic [7:0] globalConfig;
  logic [7:0] next_globalConfig;
  logic [7:0] channelOne;
  logic [7:0] next_channelOne;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] readByte;
  logic       reqOneActive;
  logic       anyRequest;
  logic       sysAsserted;
  logic       chanEnableReq;
  logic       next_sysRequestOut;
  logic       next_sysRequestOeN;
  logic       next_regulatorOn;

  // Unmapped indexes read as zero; reserved bits already stored as zero
  function automatic logic [7:0] readReg(input logic [7:0] idx,
                                         input logic [7:0] g,
                                         input logic [7:0] c);
    logic [7:0] v;
    v = 8'h00;
    if (idx == cfd_pkg::REG_GLOBAL) begin
      v = g & cfd_pkg::GLOBAL_MASK;
    end else if (idx == cfd_pkg::REG_CHAN_ONE) begin
      v = c & cfd_pkg::CHAN_MASK;
    end
    return v;
  endfunction

  assign sclRise   = scl & ~sclPrev;
  assign sclFall   = ~scl & sclPrev;
  assign startSeen = scl & sclPrev & sdaPrev & ~sdaIn;
  assign stopSeen  = scl & sclPrev & ~sdaPrev & sdaIn;
  assign readByte  = readReg(regIndex, globalConfig, channelOne);

  // Bus target and register file
  always_comb begin
    next_state        = state;
    next_bitCount     = bitCount;
    next_shiftReg     = shiftReg;
    next_regIndex     = regIndex;
    next_readMode     = readMode;
    next_sdaDrive     = sdaDrive;
    next_globalConfig = globalConfig;
    next_channelOne   = channelOne;
    if (startSeen) begin
      next_state    = cfd_pkg::S_ADDR;
      next_bitCount = 4'h0;
      next_sdaDrive = 1'b0;
    end else if (stopSeen) begin
      next_state    = cfd_pkg::S_IDLE;
      next_sdaDrive = 1'b0;
    end else begin
      unique case (state)
        cfd_pkg::S_IDLE: begin
          next_sdaDrive = 1'b0;
        end
        cfd_pkg::S_ADDR, cfd_pkg::S_INDEX, cfd_pkg::S_WDATA: begin
          if (sclRise && bitCount != cfd_pkg::BYTE_BITS) begin
            next_shiftReg = {shiftReg[6:0], sdaIn};
            next_bitCount = bitCount + 4'h1;
          end else if (sclFall && bitCount == cfd_pkg::BYTE_BITS) begin
            next_bitCount = 4'h0;
            next_sdaDrive = 1'b1;
            if (state == cfd_pkg::S_ADDR) begin
              if (shiftReg[7:1] == cfd_pkg::TARGET_ADDR) begin
                next_readMode = shiftReg[0];
                next_state    = cfd_pkg::S_ACK_ADDR;
              end else begin
                // Other targets' traffic is ignored until next start
                next_sdaDrive = 1'b0;
                next_state    = cfd_pkg::S_IDLE;
              end
            end else if (state == cfd_pkg::S_INDEX) begin
              next_regIndex = shiftReg;
              next_state    = cfd_pkg::S_ACK_INDEX;
            end else begin
              next_state = cfd_pkg::S_ACK_DATA;
            end
          end
        end
        cfd_pkg::S_ACK_ADDR: begin
          if (sclFall) begin
            // Read serves the index left by an earlier write
            if (readMode) begin
              next_shiftReg = readByte;
              next_sdaDrive = ~readByte[7];
              next_state    = cfd_pkg::S_RDATA;
            end else begin
              next_sdaDrive = 1'b0;
              next_state    = cfd_pkg::S_INDEX;
            end
          end
        end
        cfd_pkg::S_ACK_INDEX: begin
          if (sclFall) begin
            next_sdaDrive = 1'b0;
            next_state    = cfd_pkg::S_WDATA;
          end
        end
        cfd_pkg::S_ACK_DATA: begin
          if (sclRise) begin
            if (regIndex == cfd_pkg::REG_GLOBAL) begin
              next_globalConfig = shiftReg & cfd_pkg::GLOBAL_MASK;
            end else if (regIndex == cfd_pkg::REG_CHAN_ONE) begin
              next_channelOne = shiftReg & cfd_pkg::CHAN_MASK;
            end
            next_regIndex = regIndex + 8'h01;
          end else if (sclFall) begin
            next_sdaDrive = 1'b0;
            next_state    = cfd_pkg::S_WDATA;
          end
        end
        cfd_pkg::S_RDATA: begin
          if (sclFall) begin
            if (bitCount == cfd_pkg::LAST_BIT) begin
              next_bitCount = 4'h0;
              next_sdaDrive = 1'b0;
              next_regIndex = regIndex + 8'h01;
              next_state    = cfd_pkg::S_RACK;
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_sdaDrive = ~shiftReg[6];
              next_bitCount = bitCount + 4'h1;
            end
          end
        end
        cfd_pkg::S_RACK: begin
          // Host acknowledge asks for the next byte
          if (sclRise) begin
            next_state = sdaIn ? cfd_pkg::S_IDLE : cfd_pkg::S_ACK_ADDR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state        <= cfd_pkg::S_IDLE;
      bitCount     <= 4'h0;
      shiftReg     <= 8'h00;
      regIndex     <= 8'h00;
      readMode     <= 1'b0;
      sdaDrive     <= 1'b0;
      sclPrev      <= 1'b1;
      sdaPrev      <= 1'b1;
      globalConfig <= cfd_pkg::GLOBAL_RESET;
      channelOne   <= cfd_pkg::CHAN_RESET;
    end else if (clkEn) begin
      state        <= next_state;
      bitCount     <= next_bitCount;
      shiftReg     <= next_shiftReg;
      regIndex     <= next_regIndex;
      readMode     <= next_readMode;
      sdaDrive     <= next_sdaDrive;
      sclPrev      <= scl;
      sdaPrev      <= sdaIn;
      globalConfig <= next_globalConfig;
      channelOne   <= next_channelOne;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaDrive;

  // Request qualification and pin drive
  assign reqOneActive  = requestInputOne == channelOne[cfd_pkg::C_REQ_POL];
  assign anyRequest    = reqOneActive | (|otherRequests);
  assign sysAsserted   = globalConfig[cfd_pkg::G_REQ_FORCE] | anyRequest;
  assign chanEnableReq = ~channelOne[cfd_pkg::C_FORCE_OFF] &
                         (channelOne[cfd_pkg::C_FORCE_ON] | reqOneActive);

  always_comb begin
    next_sysRequestOut = sysAsserted ~^ globalConfig[cfd_pkg::G_REQ_POL];
    // Open variant drives only the asserted level, releases otherwise
    next_sysRequestOeN = globalConfig[cfd_pkg::G_REQ_OPEN] & ~sysAsserted;
    // Reserved mode 01 falls through as off
    unique case (globalConfig[cfd_pkg::G_LDO_HI:cfd_pkg::G_LDO_LO])
      cfd_pkg::LDO_FORCE: next_regulatorOn = 1'b1;
      cfd_pkg::LDO_TRACK: next_regulatorOn = anyRequest;
      default:            next_regulatorOn = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sysRequestOut   <= 1'b0;
      sysRequestOeN   <= 1'b1;
      regulatorOn     <= 1'b0;
      pairedOutputs   <= 1'b0;
      inputDcCoupled  <= 1'b0;
      loadStrengthOne <= 2'h0;
      pulldownOne     <= 1'b0;
    end else if (clkEn) begin
      sysRequestOut   <= next_sysRequestOut;
      sysRequestOeN   <= next_sysRequestOeN;
      regulatorOn     <= next_regulatorOn;
      pairedOutputs   <= globalConfig[cfd_pkg::G_OUT_MODE];
      inputDcCoupled  <= globalConfig[cfd_pkg::G_DC_COUPLED];
      loadStrengthOne <= channelOne[cfd_pkg::C_LOAD_HI:cfd_pkg::C_LOAD_LO];
      pulldownOne     <= channelOne[cfd_pkg::C_PULLDOWN];
    end
  end

  cfd_output_gate u_gate (
    .mclk      (mclk),
    .resetn    (resetn),
    .clkEn     (clkEn),
    .sourceClk (sourceClk),
    .enableReq (chanEnableReq),
    .gatedClk  (fanoutOutputOne),
    .enabled   (fanoutEnabledOne)
  );
endmodule

// *** tb/cfd_monitor.sv ***
// Port assertions for the configuration target
module cfd_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  // Bus pins
  input wire logic       scl,
  input wire logic       sdaOut,
  input wire logic       sdaOeN,
  // Clock path
  input wire logic       sourceClk,
  input wire logic [2:0] otherRequests,
  input wire logic       fanoutOutputOne,
  input wire logic       fanoutEnabledOne,
  // Configuration and request pin
  input wire logic       pairedOutputs,
  input wire logic [1:0] loadStrengthOne,
  input wire logic       regulatorOn,
  input wire logic       sysRequestOeN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_SDA_LOW_ONLY: assert property (sdaOut == 1'b0)
    else $error("data pin driven high");
  AST_SDA_SCL_LOW: assert property ($changed(sdaOeN) |-> !$past(scl))
    else $error("data drive moved while bus clock high");
  AST_ACK_STANDS: assert property ($fell(sdaOeN) |=> !sdaOeN [*6])
    else $error("data drive too short");
  AST_EN_ON_FALL: assert property ($changed(fanoutEnabledOne) |-> !$past(sourceClk))
    else $error("enable moved off a source fall");
  AST_OUT_GATED: assert property (!fanoutEnabledOne [*2] |-> !fanoutOutputOne)
    else $error("output runs while disabled");
  AST_REQ_DRIVEN: assert property ((|otherRequests) [*5] |-> !sysRequestOeN)
    else $error("request pin not driven");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !resetn |-> sdaOeN && sysRequestOeN && !regulatorOn)
    else $error("pins active in reset");
  AST_CFG_AT_ACK: assert property ($past(resetn, 3)
    && $changed({pairedOutputs, loadStrengthOne}) |-> scl && !sdaOeN)
    else $error("config changed outside final acknowledge");
  cover property ($fell(sdaOeN));
  cover property ($rose(fanoutEnabledOne));
  cover property ($changed(loadStrengthOne));
endmodule

bind cfd_config_regs cfd_monitor mon (.mclk, .resetn, .scl, .sdaOut, .sdaOeN, .sourceClk,
  .otherRequests, .fanoutOutputOne, .fanoutEnabledOne, .pairedOutputs, .loadStrengthOne,
  .regulatorOn, .sysRequestOeN);

// *** tb/cfd_host.sv ***
// Two-wire bus host model for the configuration target
module cfd_host #(
  parameter int Q = 4
) (
  // Clock and bus pins
  input  wire logic mclk,
  input  wire logic sdaOeN,
  output logic      scl,
  output logic      sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sdaHost;
  // Pull-up: a released line reads high
  assign sdaIn = sdaHost & sdaOeN;
  initial begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end
  task automatic pause;
    repeat (Q) @(posedge mclk);
  endtask
  task automatic xbit(input logic b, output logic r);
    sdaHost <= b;
    pause();
    scl <= 1'b1;
    pause();
    r = sdaIn;
    pause();
    scl <= 1'b0;
    pause();
  endtask
  task automatic start;
    sdaHost <= 1'b1;
    pause();
    scl <= 1'b1;
    pause();
    sdaHost <= 1'b0;
    pause();
    scl <= 1'b0;
    pause();
  endtask
  task automatic stop;
    sdaHost <= 1'b0;
    pause();
    scl <= 1'b1;
    pause();
    sdaHost <= 1'b1;
    pause();
  endtask
  // Ninth bit: released for target ack, or host ack level on reads
  task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                       output logic nak);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(a, nak);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, d, output logic nak);
    logic [7:0] q;
    logic       n2;
    start();
    xbyte({a, 1'b0}, 1'b1, q, nak);
    if (!nak) begin
      xbyte(idx, 1'b1, q, n2);
      xbyte(d, 1'b1, q, n2);
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    logic nak;
    start();
    xbyte({cfd_pkg::TARGET_ADDR, 1'b0}, 1'b1, d, nak);
    xbyte(idx, 1'b1, d, nak);
    start();
    xbyte({cfd_pkg::TARGET_ADDR, 1'b1}, 1'b1, d, nak);
    xbyte(8'hff, 1'b1, d, nak);
    stop();
  endtask
  // Two-byte read: host ack on the first byte asks for the next index
  task automatic rd2(input logic [7:0] idx, output logic [7:0] d0, d1);
    logic nak;
    start();
    xbyte({cfd_pkg::TARGET_ADDR, 1'b0}, 1'b1, d0, nak);
    xbyte(idx, 1'b1, d0, nak);
    start();
    xbyte({cfd_pkg::TARGET_ADDR, 1'b1}, 1'b1, d0, nak);
    xbyte(8'hff, 1'b0, d0, nak);
    xbyte(8'hff, 1'b1, d1, nak);
    stop();
  endtask
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the configuration target
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0;
  logic       resetn = 1'b1;
  logic       clkEn = 1'b1;
  logic       sourceClk = 1'b0;
  logic       requestInputOne = 1'b0;
  logic [2:0] otherRequests = 3'h0;
  logic [2:0] div = 3'h0;
  logic [1:0] loadStrengthOne;
  logic [7:0] rdata;
  logic [7:0] rdata2;
  logic       scl, sdaIn, sdaOut, sdaOeN, fanoutOutputOne, fanoutEnabledOne, nak;
  logic       pairedOutputs, inputDcCoupled, pulldownOne, regulatorOn;
  logic       sysRequestOut, sysRequestOeN;
  // Request level above register value
  logic [8:0] tbl [7] = '{9'h004, 9'h104, 9'h100, 9'h000, 9'h108, 9'h118, 9'h1ff};
  logic [6:0] expEn = 7'b0011010;
  int         errors = 0;
  int         checkCount = 0;
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    div <= div + 3'h1;
    sourceClk <= div[2];
  end
  cfd_config_regs dut (.mclk, .resetn, .clkEn, .scl, .sdaIn, .sdaOut, .sdaOeN, .sourceClk,
    .requestInputOne, .otherRequests, .fanoutOutputOne, .fanoutEnabledOne, .pairedOutputs,
    .inputDcCoupled, .loadStrengthOne, .pulldownOne, .regulatorOn, .sysRequestOut,
    .sysRequestOeN);
  cfd_host host (.mclk, .sdaOeN, .scl, .sdaIn);
  task automatic chk8(input logic [7:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic wr(input logic [7:0] idx, d);
    host.wr(cfd_pkg::TARGET_ADDR, idx, d, nak);
    chk1(nak, 1'b0);
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run needs about 13600 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    reportAndStop();
  end
  initial begin
    // Reset edge at time zero, so no flop shows unknown at the first clock
    resetn <= 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    host.rd(8'h00, rdata);
    chk8(rdata, 8'h44);
    host.rd(8'h01, rdata);
    chk8(rdata, 8'h06);
    chk1(regulatorOn, 1'b0);
    $display("test reset values done");
    wr(8'h00, 8'hff);
    host.rd(8'h00, rdata);
    chk8(rdata, 8'h7f);
    chk8({pairedOutputs, inputDcCoupled, 6'h0}, 8'hc0);
    chk8({sysRequestOut, sysRequestOeN, regulatorOn, 5'h0}, 8'ha0);
    wr(8'h00, 8'h22);
    chk8({sysRequestOut, sysRequestOeN, regulatorOn, 5'h0}, 8'hc0);
    otherRequests <= 3'h4;
    repeat (8) @(posedge mclk);
    chk8({sysRequestOut, sysRequestOeN, 6'h0}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {1'b0, m[1:0], 5'h00});
      chk1(regulatorOn, m[1]);
    end
    chk1(pairedOutputs, 1'b0);
    $display("test global register done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h01, {6'h01, c[1:0]});
      chk8({6'h0, loadStrengthOne}, {6'h0, c[1:0]});
    end
    for (int i = 0; i < 7; i++) begin
      requestInputOne <= tbl[i][8];
      wr(8'h01, tbl[i][7:0]);
      repeat (16) @(posedge mclk);
      chk1(fanoutEnabledOne, expEn[i]);
    end
    host.rd(8'h01, rdata);
    chk8(rdata, 8'h3f);
    chk1(pulldownOne, 1'b1);
    $display("test channel one done");
    host.wr(7'h39, 8'h01, 8'h00, nak);
    chk1(nak, 1'b1);
    wr(8'h02, 8'h55);
    host.rd(8'h02, rdata);
    chk8(rdata, 8'h00);
    host.rd(8'h01, rdata);
    chk8(rdata, 8'h3f);
    $display("test refusals done");
    wr(8'h01, 8'h04);
    chk1(fanoutEnabledOne, 1'b1);
    // Frozen block must ignore the request change until enabled again
    clkEn <= 1'b0;
    requestInputOne <= 1'b0;
    repeat (16) @(posedge mclk);
    chk1(fanoutEnabledOne, 1'b1);
    clkEn <= 1'b1;
    repeat (16) @(posedge mclk);
    chk1(fanoutEnabledOne, 1'b0);
    host.rd2(8'h00, rdata, rdata2);
    chk8(rdata, 8'h60);
    chk8(rdata2, 8'h04);
    $display("test clock enable and burst read done");
    reportAndStop();
  end
endmodule
